//--- include/cic_regs.vh
// Constants for the codec immediate command controller.
// The device map is reached through the device's own register port.
`ifndef CIC_REGS_VH
`define CIC_REGS_VH
// Device register map, byte addresses
`define CIC_DEV_GLOBAL_CONTROL 8'h08
`define CIC_DEV_PRESENCE 8'h0E
`define CIC_DEV_CMD_WORD 8'h60
`define CIC_DEV_RESP_WORD 8'h64
`define CIC_DEV_STATUS 8'h68
// Field positions
`define CIC_LINK_RUN_BIT 0
`define CIC_BUSY_BIT 0
`define CIC_VALID_BIT 1
`define CIC_CAD_HI 31
`define CIC_CAD_LO 28
`define CIC_PRESENCE_W 3
// Field values
`define CIC_LAUNCH_VAL 32'h0000_0003
`define CIC_DONE_VAL 2'h2
`define CIC_VENDOR_VERB 32'h000F_0000
`define CIC_ROOT_NODE 8'h00
// Own register map, byte addresses
`define CIC_CTRL 8'h00
`define CIC_STAT 8'h04
`define CIC_VERB 8'h08
`define CIC_RESP 8'h0C
`define CIC_VENDOR_BASE 8'h10
// Own register reset values
`define CIC_CTRL_RST 32'h0000_0000
`define CIC_VERB_RST 32'h0000_0000
// Control bits in own control register
`define CIC_CTRL_START 0
`define CIC_CTRL_ENUM 1
`define CIC_CTRL_LINKUP 2
// Timing
`define CIC_WAIT_MS 1
`define CIC_CLK_KHZ 10000
`define CIC_WAIT_CYC (`CIC_WAIT_MS * `CIC_CLK_KHZ)
`define CIC_POLL_LIMIT 65536
`endif

//--- design/cic_sync.v
// Two-flop synchroniser for a bus of levels.
// Assumes the input comes from outside the sys_clk domain.
`timescale 1ns/1ns
module cic_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else if (clk_en) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // cic_sync

//--- design/cic_dev_port.v
// Master for the device register port: one access at a time.
// Assumes a device answering reads one cycle after dev_rd.
`timescale 1ns/1ns
`include "cic_regs.vh"
module cic_dev_port (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    // Request from sequencer
    input wire req,
    input wire req_wr,
    input wire [7:0] req_addr,
    input wire [31:0] req_data,
    output reg done,
    output reg [31:0] rdata,
    // Device port
    output reg [7:0] dev_addr,
    output reg [31:0] dev_wdata,
    output reg dev_wr,
    output reg dev_rd,
    input wire [31:0] dev_rdata
);
    reg rd_wait_r;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dev_addr <= 8'h00;
            dev_wdata <= 32'h0000_0000;
            dev_wr <= 1'b0;
            dev_rd <= 1'b0;
            done <= 1'b0;
            rdata <= 32'h0000_0000;
            rd_wait_r <= 1'b0;
        end else if (clk_en) begin
            dev_wr <= 1'b0;
            dev_rd <= 1'b0;
            done <= 1'b0;
            if (rd_wait_r) begin
                // Read data stand only in the cycle after the strobe
                rdata <= dev_rdata;
                done <= 1'b1;
                rd_wait_r <= 1'b0;
            end else if (req && !done && !dev_wr && !dev_rd) begin
                dev_addr <= req_addr;
                dev_wdata <= req_data;
                dev_wr <= req_wr;
                dev_rd <= !req_wr;
            end else if (dev_wr) begin
                done <= 1'b1;
            end else if (dev_rd) begin
                // Device answers only after seeing the strobe
                rd_wait_r <= 1'b1;
            end
        end
    end
endmodule // cic_dev_port

//--- design/cic_host.v
// Host controller driving the codec immediate command registers.
// Assumes the device port answers reads one cycle after the strobe
// and that the front_panel_fitted input arrives from another clock domain.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`include "cic_regs.vh"
// Function
// - Root node of every codec has node identifier zero.
// - A verb is one 32-bit word: address, node, command, payload.
// - Codec address plus node identifier select exactly one node.
// - Codec address occupies verb bits 31 to 28.
// - Vendor read verb is c00F0000h with codec address in top nibble.
// - Poll busy bit 0 of status until zero before loading a verb.
// - Writing 11b to status bits 1:0 launches the loaded verb.
// - Link reset bit must be written one and read back one first.
// - Initialise only codecs whose presence bit is set.
// - The immediate pair needs no system memory buffer.
// - Table verbs go strictly one at a time: wait, load, launch.
// - Front-panel verbs only when the platform flag says jacks fitted.
module cic_host #(
    parameter WAIT_CYC = `CIC_WAIT_CYC,
    parameter POLL_LIMIT = `CIC_POLL_LIMIT
) (
    // Clock, reset, enable
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    // Software port
    input wire [7:0] sw_addr,
    input wire [31:0] sw_wdata,
    input wire sw_wr,
    input wire sw_rd,
    output reg [31:0] sw_rdata,
    // Platform condition
    input wire front_panel_fitted,
    // Device register port
    output reg [7:0] dev_addr,
    output reg [31:0] dev_wdata,
    output reg dev_wr,
    output reg dev_rd,
    input wire [31:0] dev_rdata
);
    localparam S_IDLE = 4'h0;
    localparam S_LINK_ON = 4'h1;
    localparam S_LINK_CHK = 4'h2;
    localparam S_WAIT = 4'h3;
    localparam S_PRES = 4'h4;
    localparam S_PICK = 4'h5;
    localparam S_POLL = 4'h6;
    localparam S_LOAD = 4'h7;
    localparam S_LAUNCH = 4'h8;
    localparam S_DONE_POLL = 4'h9;
    localparam S_RESP = 4'hA;
    localparam S_CLR = 4'hB;
    localparam S_FAIL = 4'hC;

    reg [3:0] state_r;
    reg [31:0] ctrl_r;
    reg [31:0] verb_r;
    reg [31:0] resp_r;
    reg [2:0] present_r;
    reg [1:0] cad_r;
    reg enum_r;
    reg busy_r;
    reg fail_r;
    reg link_up_r;
    reg [31:0] vendor_r [0:2];
    reg [31:0] cnt_r;
    reg req_r;
    reg req_wr_r;
    reg [7:0] req_addr_r;
    reg [31:0] req_data_r;
    wire done;
    wire [31:0] rdata;
    wire [7:0] p_addr;
    wire [31:0] p_wdata;
    wire p_wr;
    wire p_rd;
    wire [0:0] fp_sync;
    wire [31:0] cad_verb;
    integer i;

    cic_dev_port u_port (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .req(req_r),
        .req_wr(req_wr_r),
        .req_addr(req_addr_r),
        .req_data(req_data_r),
        .done(done),
        .rdata(rdata),
        .dev_addr(p_addr),
        .dev_wdata(p_wdata),
        .dev_wr(p_wr),
        .dev_rd(p_rd),
        .dev_rdata(dev_rdata)
    );

    // Platform flag is asynchronous to sys_clk
    cic_sync #(.W(1)) u_fp (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .d(front_panel_fitted),
        .q(fp_sync)
    );

    // address nibble; vendor verb; root node
    assign cad_verb = {2'b00, cad_r, 28'h000_0000} | `CIC_VENDOR_VERB
        | {12'h000, `CIC_ROOT_NODE, 12'h000};

    always @* begin
        dev_addr = p_addr;
        dev_wdata = p_wdata;
        dev_wr = p_wr;
        dev_rd = p_rd;
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_IDLE;
            ctrl_r <= `CIC_CTRL_RST;
            verb_r <= `CIC_VERB_RST;
            resp_r <= 32'h0000_0000;
            present_r <= 3'h0;
            cad_r <= 2'h0;
            enum_r <= 1'b0;
            busy_r <= 1'b0;
            fail_r <= 1'b0;
            link_up_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
            req_r <= 1'b0;
            req_wr_r <= 1'b0;
            req_addr_r <= 8'h00;
            req_data_r <= 32'h0000_0000;
            sw_rdata <= 32'h0000_0000;
            for (i = 0; i < 3; i = i + 1) begin
                vendor_r[i] <= 32'h0000_0000;
            end
        end else if (clk_en) begin
            sw_rdata <= 32'h0000_0000;
            if (sw_rd) begin
                case (sw_addr)
                    `CIC_CTRL: sw_rdata <= {29'h0, link_up_r, enum_r, 1'b0};
                    `CIC_STAT: sw_rdata <= {25'h0, present_r, 2'b00, fail_r, busy_r};
                    `CIC_VERB: sw_rdata <= verb_r;
                    `CIC_RESP: sw_rdata <= resp_r;
                    `CIC_VENDOR_BASE: sw_rdata <= vendor_r[0];
                    `CIC_VENDOR_BASE + 8'h04: sw_rdata <= vendor_r[1];
                    `CIC_VENDOR_BASE + 8'h08: sw_rdata <= vendor_r[2];
                    default: sw_rdata <= 32'h0000_0000;
                endcase
            end
            if (sw_wr && sw_addr == `CIC_VERB && !busy_r) begin
                verb_r <= sw_wdata;
            end
            // Gate bit must not change under a running command
            if (sw_wr && sw_addr == `CIC_CTRL && !busy_r) begin
                ctrl_r <= sw_wdata;
            end
            if (done) begin
                req_r <= 1'b0;
            end
            case (state_r)
                S_IDLE: begin
                    if (sw_wr && sw_addr == `CIC_CTRL && !busy_r) begin
                        busy_r <= 1'b1;
                        fail_r <= 1'b0;
                        enum_r <= sw_wdata[`CIC_CTRL_ENUM];
                        if (sw_wdata[`CIC_CTRL_ENUM] || !link_up_r) begin
                            state_r <= S_LINK_ON;
                        end else if (sw_wdata[`CIC_CTRL_START]) begin
                            state_r <= S_POLL;
                        end else begin
                            busy_r <= 1'b0;
                        end
                    end
                end
                S_LINK_ON: begin
                    // release link; write then read back
                    if (!req_r && !done) begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b1;
                        req_addr_r <= `CIC_DEV_GLOBAL_CONTROL;
                        req_data_r <= 32'h0000_0001;
                    end else if (done) begin
                        state_r <= S_LINK_CHK;
                        cnt_r <= 32'h0000_0000;
                    end
                end
                S_LINK_CHK: begin
                    // read back as one before any command
                    if (!req_r && !done) begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b0;
                        req_addr_r <= `CIC_DEV_GLOBAL_CONTROL;
                    end else if (done) begin
                        cnt_r <= cnt_r + 32'h1;
                        if (rdata[`CIC_LINK_RUN_BIT]) begin
                            link_up_r <= 1'b1;
                            cnt_r <= 32'h0000_0000;
                            state_r <= enum_r ? S_WAIT : S_POLL;
                        end else if (cnt_r >= POLL_LIMIT) begin
                            state_r <= S_FAIL;
                        end
                    end
                end
                S_WAIT: begin
                    // Codecs report presence after the link settles
                    cnt_r <= cnt_r + 32'h1;
                    if (cnt_r >= WAIT_CYC) begin
                        state_r <= S_PRES;
                    end
                end
                S_PRES: begin
                    // presence bit index becomes the codec address
                    if (!req_r && !done) begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b0;
                        req_addr_r <= `CIC_DEV_PRESENCE;
                    end else if (done) begin
                        present_r <= rdata[`CIC_PRESENCE_W-1:0];
                        cad_r <= 2'h0;
                        state_r <= S_PICK;
                    end
                end
                S_PICK: begin
                    if (cad_r == 2'h3) begin
                        state_r <= S_CLR;
                    end else if (present_r[cad_r]) begin
                        state_r <= S_POLL;
                    end else begin
                        cad_r <= cad_r + 2'h1;
                    end
                end
                S_POLL: begin
                    // wait for device busy clear; one at a time
                    if (!req_r && !done) begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b0;
                        req_addr_r <= `CIC_DEV_STATUS;
                    end else if (done) begin
                        cnt_r <= cnt_r + 32'h1;
                        if (!rdata[`CIC_BUSY_BIT]) begin
                            cnt_r <= 32'h0000_0000;
                            state_r <= S_LOAD;
                        end else if (cnt_r >= POLL_LIMIT) begin
                            state_r <= S_FAIL;
                        end
                    end
                end
                S_LOAD: begin
                    // one word selects one node; gates panel verbs
                    if (!req_r && !done) begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b1;
                        req_addr_r <= `CIC_DEV_CMD_WORD;
                        req_data_r <= enum_r ? cad_verb : verb_r;
                        if (!enum_r && ctrl_r[`CIC_CTRL_LINKUP] && !fp_sync[0]) begin
                            req_r <= 1'b0;
                            state_r <= S_IDLE;
                            busy_r <= 1'b0;
                        end
                    end else if (done) begin
                        state_r <= S_LAUNCH;
                    end
                end
                S_LAUNCH: begin
                    // launch with 11b; no memory buffer used
                    if (!req_r && !done) begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b1;
                        req_addr_r <= `CIC_DEV_STATUS;
                        req_data_r <= `CIC_LAUNCH_VAL;
                    end else if (done) begin
                        state_r <= S_DONE_POLL;
                    end
                end
                S_DONE_POLL: begin
                    // wait for busy clear and valid set
                    if (!req_r && !done) begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b0;
                        req_addr_r <= `CIC_DEV_STATUS;
                    end else if (done) begin
                        cnt_r <= cnt_r + 32'h1;
                        if (rdata[1:0] == `CIC_DONE_VAL) begin
                            cnt_r <= 32'h0000_0000;
                            state_r <= S_RESP;
                        end else if (cnt_r >= POLL_LIMIT) begin
                            state_r <= S_FAIL;
                        end
                    end
                end
                S_RESP: begin
                    if (!req_r && !done) begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b0;
                        req_addr_r <= `CIC_DEV_RESP_WORD;
                    end else if (done) begin
                        resp_r <= rdata;
                        if (enum_r) begin
                            vendor_r[cad_r] <= rdata;
                            cad_r <= cad_r + 2'h1;
                            state_r <= S_PICK;
                        end else begin
                            busy_r <= 1'b0;
                            state_r <= S_IDLE;
                        end
                    end
                end
                S_CLR: begin
                    // write ones back to clear found presence bits
                    if (!req_r && !done) begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b1;
                        req_addr_r <= `CIC_DEV_PRESENCE;
                        req_data_r <= {29'h0, present_r};
                    end else if (done) begin
                        busy_r <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_FAIL: begin
                    fail_r <= 1'b1;
                    busy_r <= 1'b0;
                    req_r <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // cic_host

//--- dv/cic_host_monitor.sv
// Checker for the device-side command sequencing of cic_host.
// Sees only cic_host ports; bound to every instance after the module.
`timescale 1ns/1ns
`include "cic_regs.vh"
module cic_host_monitor (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    // Software port
    input wire [7:0] sw_addr,
    input wire [31:0] sw_wdata,
    input wire sw_wr,
    input wire sw_rd,
    input wire [31:0] sw_rdata,
    input wire front_panel_fitted,
    // Device port
    input wire [7:0] dev_addr,
    input wire [31:0] dev_wdata,
    input wire dev_wr,
    input wire dev_rd,
    input wire [31:0] dev_rdata
);
    reg rd_q_r;
    reg [7:0] rd_addr_r;
    reg idle_r;
    reg link_r;
    reg loaded_r;
    reg done_r;
    reg [2:0] pres_r;
    wire launch = dev_wr && dev_addr == `CIC_DEV_STATUS;
    wire load = dev_wr && dev_addr == `CIC_DEV_CMD_WORD;
    wire st_back = rd_q_r && rd_addr_r == `CIC_DEV_STATUS;
    wire ctl_back = rd_q_r && rd_addr_r == `CIC_DEV_GLOBAL_CONTROL;
    wire link_off = dev_wr && dev_addr == `CIC_DEV_GLOBAL_CONTROL && !dev_wdata[0];

    // Read data land one cycle after the strobe, so track what was asked
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q_r <= 1'b0;
            rd_addr_r <= 8'h00;
            idle_r <= 1'b0;
            link_r <= 1'b0;
            loaded_r <= 1'b0;
            done_r <= 1'b0;
            pres_r <= 3'h0;
        end else begin
            rd_q_r <= dev_rd;
            rd_addr_r <= dev_addr;
            if (st_back && !dev_rdata[0]) idle_r <= 1'b1;
            else if (load) idle_r <= 1'b0;
            if (ctl_back && dev_rdata[0]) link_r <= 1'b1;
            else if (link_off) link_r <= 1'b0;
            if (load) loaded_r <= 1'b1;
            else if (launch) loaded_r <= 1'b0;
            if (st_back && dev_rdata[1:0] == `CIC_DONE_VAL) done_r <= 1'b1;
            else if (launch) done_r <= 1'b0;
            if (rd_q_r && rd_addr_r == `CIC_DEV_PRESENCE) pres_r <= dev_rdata[2:0];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence strobe_s; dev_wr || dev_rd; endsequence
    sequence launch_s; dev_wr && dev_addr == `CIC_DEV_STATUS; endsequence
    sequence poll_s; dev_rd && dev_addr == `CIC_DEV_STATUS; endsequence
    sequence resp_rd_s; dev_rd && dev_addr == `CIC_DEV_RESP_WORD; endsequence

    rdata_slot_a: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
        else $error("read data outside the read slot");
    strobe_excl_a: assert property (!(dev_wr && dev_rd))
        else $error("device read and write together");
    strobe_gap_a: assert property (strobe_s |=> !(dev_wr || dev_rd))
        else $error("device strobes too close");
    launch_code_a: assert property (launch_s |-> dev_wdata[1:0] == 2'h3)
        else $error("launch without 11b");
    load_first_a: assert property (launch_s |-> loaded_r)
        else $error("launch without a loaded verb");
    poll_first_a: assert property (load |-> idle_r)
        else $error("verb loaded without idle poll");
    link_first_a: assert property (load |-> link_r)
        else $error("verb loaded before link read back up");
    done_first_a: assert property (resp_rd_s |-> done_r)
        else $error("response read before 10b seen");
    poll_after_a: assert property (launch_s |=> ##[1:16] poll_s)
        else $error("no status poll after launch");
    present_only_a: assert property (load && dev_wdata[27:0] == 28'h00F_0000 |->
        dev_wdata[31:28] < 4'h3 && pres_r[dev_wdata[29:28]])
        else $error("vendor verb to absent codec");
endmodule // cic_host_monitor

bind cic_host cic_host_monitor i_mon (.sys_clk, .arst_n, .clk_en, .sw_addr, .sw_wdata,
    .sw_wr, .sw_rd, .sw_rdata, .front_panel_fitted, .dev_addr, .dev_wdata, .dev_wr,
    .dev_rd, .dev_rdata);

//--- dv/cic_dev_model.sv
// Behavioural audio link controller seen through its register port.
// Assumes strobes change just after sys_clk edges; reads answer next cycle.
`timescale 1ns/1ns
`include "cic_regs.vh"
module cic_dev_model #(
    parameter [2:0] PRESENT = 3'h5,
    parameter [7:0] DELAY = 8'h0C,
    // Arbitrary identity value
    parameter [31:0] VENDOR_ID = 32'h5A5A_0000
) (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    // Register port
    input wire [7:0] dev_addr,
    input wire [31:0] dev_wdata,
    input wire dev_wr,
    input wire dev_rd,
    output reg [31:0] dev_rdata,
    // Test control and observation
    input wire hang,
    output reg [15:0] launches,
    output reg [31:0] last_verb,
    output reg [2:0] pres_r
);
    reg link_r;
    reg busy_r;
    reg valid_r;
    reg [31:0] resp_r;
    reg [7:0] cnt_r;
    wire ctl_wr = dev_wr && dev_addr == `CIC_DEV_GLOBAL_CONTROL;

    // root node of addressed codec gives vendor pair
    function [31:0] answer(input [31:0] v);
        answer = (v[27:0] == 28'h00F_0000) ? VENDOR_ID ^ {28'h0, v[31:28]} : ~v;
    endfunction

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_r <= 1'b0;
            busy_r <= 1'b0;
            valid_r <= 1'b0;
            resp_r <= 32'h0;
            cnt_r <= 8'h00;
            launches <= 16'h0;
            last_verb <= 32'h0;
            pres_r <= 3'h0;
            dev_rdata <= 32'h0;
        end else begin
            // no buffer: outside a read slot the data invert every cycle, so stale data come back every second cycle
            dev_rdata <= ~dev_rdata;
            if (dev_rd) begin
                case (dev_addr)
                    `CIC_DEV_GLOBAL_CONTROL: dev_rdata <= {31'h0, link_r};
                    `CIC_DEV_PRESENCE: dev_rdata <= {29'h0, pres_r};
                    `CIC_DEV_CMD_WORD: dev_rdata <= last_verb;
                    `CIC_DEV_RESP_WORD: dev_rdata <= resp_r;
                    `CIC_DEV_STATUS: dev_rdata <= {30'h0, valid_r, busy_r};
                    default: dev_rdata <= 32'h0;
                endcase
            end
            if (dev_wr && dev_addr == `CIC_DEV_PRESENCE) pres_r <= pres_r & ~dev_wdata[2:0];
            if (dev_wr && dev_addr == `CIC_DEV_CMD_WORD) last_verb <= dev_wdata;
            if (dev_wr && dev_addr == `CIC_DEV_STATUS && dev_wdata[1:0] == 2'h3 && link_r
                && !busy_r) begin
                busy_r <= 1'b1;
                valid_r <= 1'b0;
                cnt_r <= DELAY;
                launches <= launches + 16'h1;
            end else if (busy_r && !hang) begin
                cnt_r <= cnt_r - 8'h1;
                if (cnt_r == 8'h01) begin
                    busy_r <= 1'b0;
                    valid_r <= 1'b1;
                    resp_r <= answer(last_verb);
                end
            end
            if (ctl_wr) begin
                link_r <= dev_wdata[0];
                // link start enumerates codecs by input line
                if (dev_wdata[0] && !link_r) pres_r <= PRESENT;
                // link held in reset drops busy
                if (!dev_wdata[0]) busy_r <= 1'b0;
            end
        end
    end
endmodule // cic_dev_model

//--- dv/cic_host_bench.sv
// Self-checking bench: cic_host driving the behavioural device model.
// Assumes the designer's own register map and shortened wait counts.
`timescale 1ns/1ns
`include "cic_regs.vh"
module cic_host_bench;
    // Arbitrary identity value
    localparam [31:0] VID = 32'h5A5A_0000;
    reg sys_clk;
    reg arst_n;
    reg sw_wr;
    reg sw_rd;
    reg fp_fit;
    reg hang;
    reg [7:0] sw_addr;
    reg [31:0] sw_wdata;
    reg [31:0] rv;
    wire [31:0] sw_rdata, dev_wdata, dev_rdata, last_verb;
    wire [7:0] dev_addr;
    wire dev_wr, dev_rd;
    wire [15:0] launches;
    wire [2:0] pres;
    integer err_count, n_compared, i;

    cic_host #(.WAIT_CYC(20), .POLL_LIMIT(16)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .clk_en(1'b1), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .front_panel_fitted(fp_fit), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
    cic_dev_model #(.VENDOR_ID(VID)) i_dev (.sys_clk(sys_clk), .arst_n(arst_n),
        .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
        .dev_rdata(dev_rdata), .hang(hang), .launches(launches), .last_verb(last_verb),
        .pres_r(pres));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task final_report;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task check(input [8*10-1:0] what, input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            sw_addr <= a;
            sw_wdata <= d;
            sw_wr <= 1'b1;
            @(posedge sys_clk);
            sw_wr <= 1'b0;
        end
    endtask

    // Data stand only in the cycle after the strobe is taken
    task rd(input [7:0] a, output [31:0] d);
        begin
            @(posedge sys_clk);
            sw_addr <= a;
            sw_rd <= 1'b1;
            @(posedge sys_clk);
            sw_rd <= 1'b0;
            #1 d = sw_rdata;
        end
    endtask

    task wait_idle;
        integer k;
        begin
            rv = 32'h1;
            for (k = 0; k < 300 && rv[0] !== 1'b0; k = k + 1) rd(`CIC_STAT, rv);
            if (rv[0] !== 1'b0) begin
                err_count = err_count + 1;
                $display("CHECK FAILED busy expected 0 seen 1");
                final_report;
            end
        end
    endtask

    initial begin
        arst_n = 1'b0;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        sw_addr = 8'h00;
        sw_wdata = 32'h0;
        fp_fit = 1'b0;
        hang = 1'b0;
        err_count = 0;
        n_compared = 0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(`CIC_CTRL, rv); check("ctrl", rv, `CIC_CTRL_RST);
        rd(`CIC_VERB, rv); check("verb", rv, `CIC_VERB_RST);
        rd(`CIC_STAT, rv); check("stat", rv, 32'h0);
        rd(8'h40, rv); check("unmapped", rv, 32'h0);
        wr(`CIC_CTRL, 32'h2);
        wait_idle;
        rd(`CIC_VENDOR_BASE, rv); check("vendor0", rv, VID);
        rd(`CIC_VENDOR_BASE + 8'h08, rv); check("vendor2", rv, VID ^ 32'h2);
        rd(`CIC_STAT, rv); check("present", {29'h0, rv[6:4]}, 32'h5);
        check("cleared", {29'h0, pres}, 32'h0);
        check("enum_sent", {16'h0, launches}, 32'h2);
        for (i = 0; i < 3; i = i + 1) begin
            wr(`CIC_VERB, 32'h1127_1C11 + i);
            wr(`CIC_CTRL, 32'h1);
            wr(`CIC_VERB, 32'h0);
            rd(`CIC_VERB, rv); check("verb_hold", rv, 32'h1127_1C11 + i);
            wait_idle;
            check("no_fail", {31'h0, rv[1]}, 32'h0);
            rd(`CIC_RESP, rv); check("resp", rv, ~(32'h1127_1C11 + i));
            check("sent", last_verb, 32'h1127_1C11 + i);
        end
        check("launches", {16'h0, launches}, 32'h5);
        wr(`CIC_VERB, 32'h1147_1C02);
        wr(`CIC_CTRL, 32'h5);
        wait_idle;
        check("gated", {16'h0, launches}, 32'h5);
        fp_fit <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(`CIC_CTRL, 32'h5);
        wait_idle;
        check("ungated", {16'h0, launches}, 32'h6);
        hang <= 1'b1;
        wr(`CIC_CTRL, 32'h1);
        wait_idle;
        check("timeout", {31'h0, rv[1]}, 32'h1);
        hang <= 1'b0;
        final_report;
    end
endmodule // cic_host_bench
